// File: hw/broken_conductor_detector.sv
`timescale 1ns/10ps
module broken_conductor_detector
	import bcd_pkg::*;
#(
	parameter int CYCLES_PER_MS = CYC_PER_MS
) (
	input wire logic core_clk, // system clock, 50 MHz
	input wire logic sys_rst, // synchronous reset, active high
	input wire seq_pair_type seq_in, // sequence magnitudes from upstream
	input wire settings_type settings, // operation, start-only, limit, delay
	input wire logic user_block_input, // user blocking, asynchronous level
	output logic general_start_flag, // start decision
	output logic general_trip_flag, // trip decision
	output events_type flag_events // one-cycle transition pulses
);
	logic block_meta;
	logic block_sync;
	logic [PCT_W-1:0] limit_eff;
	logic [DELAY_W-1:0] delay_eff;
	logic [MAG_W+7:0] neg_scaled;
	logic [MAG_W+7:0] pos_scaled;
	logic [MAG_W+15:0] i1_scaled;
	logic [MAG_W+15:0] i1_lo;
	logic [MAG_W+15:0] i1_hi;
	logic ratio_over;
	logic i1_window;
	logic enabled;
	logic next_start;
	logic timer_expired;
	logic next_trip;
	logic start_prev;
	logic trip_prev;

	// pin-level block input passes two flops first
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			block_meta <= 1'b0;
			block_sync <= 1'b0;
		end else begin
			block_meta <= user_block_input;
			block_sync <= block_meta;
		end
	end

	// out-of-range settings are clamped rather than rejected
	always_comb begin
		if (settings.ratio_limit_setting < RATIO_MIN) begin
			limit_eff = RATIO_MIN;
		end else if (settings.ratio_limit_setting > RATIO_MAX) begin
			limit_eff = RATIO_MAX;
		end else begin
			limit_eff = settings.ratio_limit_setting;
		end
		if (settings.time_delay_ms < DELAY_MIN_MS) begin
			delay_eff = DELAY_MIN_MS;
		end else if (settings.time_delay_ms > DELAY_MAX_MS) begin
			delay_eff = DELAY_MAX_MS;
		end else begin
			delay_eff = settings.time_delay_ms;
		end
	end

	// cross-multiplied so no divider is needed: 100*I2 > limit*I1
	always_comb begin
		neg_scaled = (MAG_W+8)'(seq_in.negative_seq_magnitude) * (MAG_W+8)'(PCT_FULL);
		pos_scaled = (MAG_W+8)'(seq_in.positive_seq_magnitude) * (MAG_W+8)'(limit_eff);
		i1_scaled = (MAG_W+16)'(seq_in.positive_seq_magnitude) * (MAG_W+16)'(BP_FULL);
		i1_lo = (MAG_W+16)'(RATED_MAG) * (MAG_W+16)'(I1_MIN_BP);
		i1_hi = (MAG_W+16)'(RATED_MAG) * (MAG_W+16)'(I1_MAX_BP);
		ratio_over = (neg_scaled > pos_scaled);
		i1_window = (i1_scaled >= i1_lo) && (i1_scaled <= i1_hi);
		enabled = settings.operation_on && !block_sync;
		next_start = enabled && ratio_over && i1_window;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			general_start_flag <= 1'b0;
		end else begin
			general_start_flag <= next_start;
		end
	end

	// timer runs on the raw condition so its count begins at fault onset
	ms_timer #(
		.CYCLES_PER_MS(CYCLES_PER_MS)
	) delay_timer (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.run(next_start),
		.target_ms(delay_eff),
		.expired(timer_expired)
	);

	always_comb begin
		next_trip = next_start && timer_expired && !settings.start_signal_only;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			general_trip_flag <= 1'b0;
		end else begin
			general_trip_flag <= next_trip;
		end
	end

	// previous flag values turn registered level changes into events one cycle later
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			start_prev <= 1'b0;
			trip_prev <= 1'b0;
		end else begin
			start_prev <= general_start_flag;
			trip_prev <= general_trip_flag;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			flag_events <= '0;
		end else begin
			flag_events.start_on <= general_start_flag && !start_prev;
			flag_events.start_off <= !general_start_flag && start_prev;
			flag_events.trip_on <= general_trip_flag && !trip_prev;
			flag_events.trip_off <= !general_trip_flag && trip_prev;
		end
	end

	off_forces_low_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(!settings.operation_on || block_sync) |=> (!general_start_flag && !general_trip_flag))
		else $error("flags active while disabled");
	start_needs_window_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		general_start_flag |-> $past(i1_window) && $past(ratio_over))
		else $error("start without ratio or window");
	window_blocks_start_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!i1_window |=> !general_start_flag)
		else $error("start outside current window");
	trip_needs_start_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		general_trip_flag |-> general_start_flag)
		else $error("trip without start");
	start_only_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		settings.start_signal_only |=> !general_trip_flag)
		else $error("trip in start-only mode");
	limit_range_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		limit_eff >= RATIO_MIN && limit_eff <= RATIO_MAX)
		else $error("ratio limit outside range");
	trip_drop_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		$fell(general_start_flag) |-> !general_trip_flag ##1 !general_trip_flag)
		else $error("trip held after start loss");
	start_event_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(general_start_flag) |=> flag_events.start_on && !flag_events.start_off)
		else $error("missing start-on event");
	trip_event_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		$fell(general_trip_flag) |=> flag_events.trip_off)
		else $error("missing trip-off event");
	trip_not_early_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(general_trip_flag) |-> $past(general_start_flag, 2))
		else $error("trip too soon after onset");

	// flags track the decision one cycle late in both directions
	start_follows_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		next_start |=> general_start_flag)
		else $error("start did not follow condition");
	start_drops_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!next_start |=> !general_start_flag)
		else $error("start held without condition");
	trip_follows_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		next_trip |=> general_trip_flag)
		else $error("trip did not follow decision");
	trip_clears_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		!next_trip |=> !general_trip_flag)
		else $error("trip held without decision");
	ratio_strict_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(neg_scaled == pos_scaled) |=> !general_start_flag)
		else $error("start at ratio equal to limit");
	window_upper_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(seq_in.positive_seq_magnitude > RATED_MAG) |=> !general_start_flag)
		else $error("start above rated current");
	window_lower_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(i1_scaled < i1_lo) |=> !general_start_flag)
		else $error("start below minimum current");
	delay_range_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		delay_eff >= DELAY_MIN_MS && delay_eff <= DELAY_MAX_MS)
		else $error("delay outside range");
	limit_pass_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		(settings.ratio_limit_setting >= RATIO_MIN && settings.ratio_limit_setting <= RATIO_MAX)
		|-> (limit_eff == settings.ratio_limit_setting))
		else $error("legal ratio limit altered");
	block_pipe_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		block_sync |-> $past(block_meta))
		else $error("block synchroniser skipped a stage");
	trip_on_event_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		$rose(general_trip_flag) |=> flag_events.trip_on)
		else $error("missing trip-on event");
	start_off_event_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		$fell(general_start_flag) |=> flag_events.start_off)
		else $error("missing start-off event");
	start_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		flag_events.start_on |=> !flag_events.start_on)
		else $error("start-on event longer than one cycle");
	trip_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		flag_events.trip_on |=> !flag_events.trip_on)
		else $error("trip-on event longer than one cycle");
	expired_needs_run_a: assert property (@(posedge core_clk) disable iff (sys_rst)
		timer_expired |-> $past(next_start))
		else $error("timer expired without running");
endmodule // broken_conductor_detector

// File: hw/bcd_pkg.sv
package bcd_pkg;
	localparam int MAG_W = 16;
	// magnitudes are scaled so that rated current equals RATED_MAG
	localparam logic [MAG_W-1:0] RATED_MAG = 16'h2710;
	// lower window edge 6.67 % of rated, held as hundredths of a percent
	localparam int I1_MIN_BP = 667;
	localparam int I1_MAX_BP = 10000;
	localparam int BP_FULL = 10000;
	localparam int PCT_W = 7;
	localparam logic [PCT_W-1:0] RATIO_MIN = 7'h0A;
	localparam logic [PCT_W-1:0] RATIO_MAX = 7'h5A;
	localparam logic [PCT_W-1:0] RATIO_DEFAULT = 7'h32;
	localparam int PCT_FULL = 100;
	localparam int DELAY_W = 16;
	localparam logic [DELAY_W-1:0] DELAY_MIN_MS = 16'h0064;
	localparam logic [DELAY_W-1:0] DELAY_MAX_MS = 16'hEA60;
	localparam logic [DELAY_W-1:0] DELAY_DEFAULT_MS = 16'h03E8;
	localparam int CLK_HZ = 50000000;
	localparam int MS_PER_S = 1000;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;
	localparam int MS_TICK_W = 16;

	typedef struct packed {
		logic [MAG_W-1:0] positive_seq_magnitude;
		logic [MAG_W-1:0] negative_seq_magnitude;
	} seq_pair_type;

	typedef struct packed {
		logic operation_on;
		logic start_signal_only;
		logic [PCT_W-1:0] ratio_limit_setting;
		logic [DELAY_W-1:0] time_delay_ms;
	} settings_type;

	typedef struct packed {
		logic start_on;
		logic start_off;
		logic trip_on;
		logic trip_off;
	} events_type;
endpackage

// File: hw/ms_timer.sv
`timescale 1ns/10ps
module ms_timer
	import bcd_pkg::*;
#(
	parameter int CYCLES_PER_MS = CYC_PER_MS
) (
	input wire logic core_clk, // system clock
	input wire logic sys_rst, // synchronous reset
	input wire logic run, // count while high, clear while low
	input wire logic [DELAY_W-1:0] target_ms, // delay to reach
	output logic expired // target reached, holds while run
);
	logic [MS_TICK_W-1:0] tick_cnt;
	logic [DELAY_W-1:0] ms_cnt;

	// dropping run restarts from zero so a chattering start never accumulates
	always_ff @(posedge core_clk) begin
		if (sys_rst || !run) begin
			tick_cnt <= '0;
		end else if (tick_cnt == MS_TICK_W'(CYCLES_PER_MS - 1)) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || !run) begin
			ms_cnt <= '0;
		end else if (tick_cnt == MS_TICK_W'(CYCLES_PER_MS - 1) && ms_cnt != target_ms) begin
			ms_cnt <= ms_cnt + 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst || !run) begin
			expired <= 1'b0;
		end else begin
			expired <= (ms_cnt >= target_ms);
		end
	end
endmodule // ms_timer

// File: test/seq_source.sv
`timescale 1ns/10ps
module seq_source
	import bcd_pkg::*;
(
	input wire logic core_clk, // clock
	input wire logic [MAG_W-1:0] i1_req, // positive magnitude to present
	input wire logic [MAG_W-1:0] i2_req, // negative magnitude to present
	output seq_pair_type seq_in // magnitude pair to the detector
);
	// both move on one edge so the detector never sees a torn pair
	always_ff @(posedge core_clk) begin
		seq_in <= '{i1_req, i2_req};
	end
endmodule // seq_source

// File: test/broken_conductor_detector_tb.sv
`timescale 1ns/10ps
module broken_conductor_detector_tb;
	import bcd_pkg::*;
	typedef struct {logic on; logic [15:0] a; logic [15:0] b; logic [6:0] lim; logic st;} row_type;
	logic core_clk, sys_rst, user_block_input, general_start_flag, general_trip_flag;
	logic [MAG_W-1:0] i1, i2;
	seq_pair_type seq_in;
	settings_type settings;
	events_type flag_events;
	int fails, checks_done, trip_ons, trip_offs, n;
	// limits 7'h05 and 7'h7F land outside the legal range and should clamp to 10 and 90
	row_type rows[12] = '{
		'{1'b1, 16'h1388, 16'h0A28, 7'h32, 1'b1}, '{1'b1, 16'h1388, 16'h09C4, 7'h32, 1'b0},
		'{1'b1, 16'h029A, 16'h0258, 7'h32, 1'b0}, '{1'b1, 16'h029B, 16'h0258, 7'h32, 1'b1},
		'{1'b1, 16'h2710, 16'h2328, 7'h32, 1'b1}, '{1'b1, 16'h2711, 16'h2328, 7'h32, 1'b0},
		'{1'b0, 16'h1388, 16'h0A28, 7'h32, 1'b0}, '{1'b1, 16'h1388, 16'h0258, 7'h05, 1'b1},
		'{1'b1, 16'h1388, 16'h0190, 7'h05, 1'b0}, '{1'b1, 16'h1388, 16'h11F8, 7'h7F, 1'b1},
		'{1'b1, 16'h1388, 16'h1130, 7'h7F, 1'b0}, '{1'b1, 16'h1388, 16'h1130, 7'h55, 1'b1}};
	seq_source seq_source_inst(.core_clk(core_clk), .i1_req(i1), .i2_req(i2), .seq_in(seq_in));
	broken_conductor_detector #(.CYCLES_PER_MS(4)) broken_conductor_detector_inst(.core_clk(core_clk),
		.sys_rst(sys_rst), .seq_in(seq_in), .settings(settings), .user_block_input(user_block_input),
		.general_start_flag(general_start_flag), .general_trip_flag(general_trip_flag),
		.flag_events(flag_events));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	always @(posedge core_clk) if (flag_events.trip_on === 1'b1) trip_ons <= trip_ons + 1;
	always @(posedge core_clk) if (flag_events.trip_off === 1'b1) trip_offs <= trip_offs + 1;
	task check_bit(input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: expected %h got %h", $time, exp, got);
		end
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// outputs are read 1 ns after the edge so that edge's updates have landed
	task cyc(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task apply(input logic on, input logic [15:0] a, input logic [15:0] b, input logic [6:0] lim);
		@(posedge core_clk);
		settings.operation_on <= on;
		settings.ratio_limit_setting <= lim;
		i1 <= a;
		i2 <= b;
	endtask
	task wait_trip(output int c);
		c = 0;
		while (general_trip_flag !== 1'b1) begin
			cyc(1);
			c++;
			if (c > 2000) begin
				fails++;
				final_report;
			end
		end
	endtask
	initial begin
		sys_rst = 1'b1;
		settings = '{1'b0, 1'b0, 7'h32, 16'h0000};
		user_block_input = 1'b0;
		i1 = 16'h0000;
		i2 = 16'h0000;
		trip_ons = 0;
		trip_offs = 0;
		cyc(2);
		check_bit(1'b0, general_start_flag | general_trip_flag);
		@(posedge core_clk) sys_rst <= 1'b0;
		foreach (rows[k]) begin
			apply(rows[k].on, rows[k].a, rows[k].b, rows[k].lim);
			cyc(4);
			check_bit(rows[k].st, general_start_flag);
		end
		@(posedge core_clk) user_block_input <= 1'b1;
		cyc(5);
		check_bit(1'b0, general_start_flag);
		@(posedge core_clk) user_block_input <= 1'b0;
		apply(1'b0, 16'h1388, 16'h0A28, 7'h32);
		cyc(4);
		apply(1'b1, 16'h1388, 16'h0A28, 7'h32);
		wait_trip(n);
		check_bit(1'b1, n >= 395 && n <= 410);
		cyc(3);
		check_bit(1'b1, trip_ons == 1);
		apply(1'b1, 16'h1388, 16'h09C4, 7'h32);
		cyc(4);
		check_bit(1'b0, general_trip_flag);
		check_bit(1'b1, trip_offs == 1);
		apply(1'b1, 16'h1388, 16'h0A28, 7'h32);
		cyc(300);
		check_bit(1'b0, general_trip_flag);
		wait_trip(n);
		@(posedge core_clk) settings.start_signal_only <= 1'b1;
		cyc(5);
		check_bit(1'b0, general_trip_flag);
		check_bit(1'b1, general_start_flag);
		final_report;
	end
endmodule // broken_conductor_detector_tb
